// ===== src/tid_tap.sv
/*
 * Boundary-scan test access port of the memory: TAP controller,
 * instruction register, bypass, identification and boundary chain.
 * Assumes test pins arrive asynchronously to clock, which runs well
 * above the test clock so its edges can be found by sampling.
 */
`include "tid_defines.svh"

// Behaviour
// - Sample-Z holds memory outputs high-impedance, captures ring
// - Sample-Z shifts the boundary chain in Shift-DR
// - Reserved codes behave exactly like bypass
// - All-zeros code selects the boundary chain
// - Sample/preload captures ring, selects chain, outputs untouched
// - Identification code preloads and selects the ID register
// - Identification instruction loaded at reset and Test-Logic-Reset
// - All-ones code selects the single-bit bypass
// - Codes read MSB leftmost, LSB rightmost
// - Instruction register three bits, loaded when selected
// - Capture-IR loads 01 into low bits
// - New instruction applies only at Update-IR
// - Five high TMS edges enter Test-Logic-Reset
module tid_tap
    import tid_pkg::*;
#(
    parameter int BSR_W = `TID_BSR_W,
    parameter logic [`TID_ID_W-1:0] ID_VALUE = `TID_ID_VALUE
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Test pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // Memory ring levels and output control
    input wire logic [BSR_W-1:0] ring_in,
    output logic mem_out_hiz,
    output logic [BSR_W-1:0] ring_out,
    output logic extest_drive
);

    logic [1:0] rst_sync;
    logic rst_s_n;
    logic [2:0] pin_a;
    logic [2:0] pin_b;
    logic tck_q;
    logic tck_rise;
    logic tck_fall;
    tid_state_t state;
    tid_state_t next_state;
    logic [`TID_IR_W-1:0] ir_shift;
    logic [`TID_IR_W-1:0] ir;
    logic bypass_bit;
    logic [`TID_ID_W-1:0] id_shift;
    logic [BSR_W-1:0] bsr;
    logic [BSR_W-1:0] bsr_upd;
    logic [BSR_W-1:0] ring_a;
    logic [BSR_W-1:0] ring_b;
    logic tdo_next;
    tid_path_t path;
    logic force_hiz;

    // Reset release through two flip-flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_s_n = rst_sync[1];

    // Two-stage synchronisers for tck, tms, tdi
    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            pin_a <= 3'h0;
            pin_b <= 3'h0;
            tck_q <= 1'b0;
        end else begin
            pin_a <= {tck, tms, tdi};
            pin_b <= pin_a;
            tck_q <= pin_b[2];
        end
    end
    assign tck_rise = pin_b[2] & ~tck_q;
    assign tck_fall = ~pin_b[2] & tck_q;

    // Ring levels follow the memory's own timing; two stages before capture
    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            ring_a <= '0;
            ring_b <= '0;
        end else begin
            ring_a <= ring_in;
            ring_b <= ring_a;
        end
    end

    // Next TAP state from synchronised tms; five highs reach reset
    always_comb begin
        case (state)
            TID_RESET: next_state = pin_b[1] ? TID_RESET : TID_IDLE;
            TID_IDLE: next_state = pin_b[1] ? TID_SEL_DR : TID_IDLE;
            TID_SEL_DR: next_state = pin_b[1] ? TID_SEL_IR : TID_CAP_DR;
            TID_CAP_DR: next_state = pin_b[1] ? TID_EX1_DR : TID_SHF_DR;
            TID_SHF_DR: next_state = pin_b[1] ? TID_EX1_DR : TID_SHF_DR;
            TID_EX1_DR: next_state = pin_b[1] ? TID_UPD_DR : TID_PAU_DR;
            TID_PAU_DR: next_state = pin_b[1] ? TID_EX2_DR : TID_PAU_DR;
            TID_EX2_DR: next_state = pin_b[1] ? TID_UPD_DR : TID_SHF_DR;
            TID_UPD_DR: next_state = pin_b[1] ? TID_SEL_DR : TID_IDLE;
            TID_SEL_IR: next_state = pin_b[1] ? TID_RESET : TID_CAP_IR;
            TID_CAP_IR: next_state = pin_b[1] ? TID_EX1_IR : TID_SHF_IR;
            TID_SHF_IR: next_state = pin_b[1] ? TID_EX1_IR : TID_SHF_IR;
            TID_EX1_IR: next_state = pin_b[1] ? TID_UPD_IR : TID_PAU_IR;
            TID_PAU_IR: next_state = pin_b[1] ? TID_EX2_IR : TID_PAU_IR;
            TID_EX2_IR: next_state = pin_b[1] ? TID_UPD_IR : TID_SHF_IR;
            TID_UPD_IR: next_state = pin_b[1] ? TID_SEL_DR : TID_IDLE;
            default: next_state = TID_RESET;
        endcase
    end

    // State advances on each test clock rising edge; power-up is reset
    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            state <= TID_RESET;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // Instruction shift register, selected only in the IR column
    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            ir_shift <= `TID_OP_IDCODE;
        end else if (tck_rise) begin
            if (state == TID_CAP_IR) begin
                ir_shift <= {1'b0, `TID_IR_CAPTURE};
            end else if (state == TID_SHF_IR) begin
                ir_shift <= {pin_b[0], ir_shift[`TID_IR_W-1:1]};
            end
        end
    end

    // Instruction in force changes only at Update-IR or reset
    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            ir <= `TID_OP_IDCODE;
        end else if (state == TID_RESET) begin
            ir <= `TID_OP_IDCODE;
        end else if (tck_fall && state == TID_UPD_IR) begin
            ir <= ir_shift;
        end
    end

    tid_decode u_decode (
        .instr(ir),
        .path(path),
        .force_hiz(force_hiz)
    );

    // Data registers: capture and shift on the selected path
    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            bypass_bit <= 1'b0;
            id_shift <= '0;
            bsr <= '0;
        end else if (tck_rise && state == TID_CAP_DR) begin
            bypass_bit <= 1'b0;
            if (path == TID_PATH_ID) begin
                id_shift <= ID_VALUE;
            end
            if (path == TID_PATH_BSR) begin
                bsr <= ring_b;
            end
        end else if (tck_rise && state == TID_SHF_DR) begin
            case (path)
                TID_PATH_BYP: bypass_bit <= pin_b[0];
                TID_PATH_ID: id_shift <= {pin_b[0], id_shift[`TID_ID_W-1:1]};
                TID_PATH_BSR: bsr <= {pin_b[0], bsr[BSR_W-1:1]};
                default: bypass_bit <= pin_b[0];
            endcase
        end
    end

    // Serial output source for the current state and path
    always_comb begin
        if (state == TID_SHF_IR) begin
            tdo_next = ir_shift[0];
        end else begin
            case (path)
                TID_PATH_ID: tdo_next = id_shift[0];
                TID_PATH_BSR: tdo_next = bsr[0];
                default: tdo_next = bypass_bit;
            endcase
        end
    end

    // Serial output changes on the test clock falling edge
    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo <= tdo_next;
            tdo_oe <= (state == TID_SHF_IR) || (state == TID_SHF_DR);
        end
    end

    // Boundary update latch and memory output controls
    always_ff @(posedge clock or negedge rst_s_n) begin
        if (!rst_s_n) begin
            bsr_upd <= '0;
            ring_out <= '0;
            mem_out_hiz <= 1'b0;
            extest_drive <= 1'b0;
        end else begin
            if (tck_fall && state == TID_UPD_DR && path == TID_PATH_BSR) begin
                bsr_upd <= bsr;
            end
            ring_out <= bsr_upd;
            mem_out_hiz <= force_hiz;
            extest_drive <= (ir == `TID_OP_EXTEST);
        end
    end

endmodule

// ===== include/tid_defines.svh
/*
 * Holds the instruction codes, register lengths and reset values of the
 * boundary-scan test port. Assumes inclusion by bare name from design files.
 */
`ifndef TID_DEFINES_SVH
`define TID_DEFINES_SVH

// Instruction width and codes, MSB written leftmost
`define TID_IR_W 3
`define TID_OP_EXTEST 3'h0
`define TID_OP_IDCODE 3'h1
`define TID_OP_SAMPLE_Z 3'h2
`define TID_OP_RSV_A 3'h3
`define TID_OP_SAMPLE 3'h4
`define TID_OP_RSV_B 3'h5
`define TID_OP_RSV_C 3'h6
`define TID_OP_BYPASS 3'h7
// Fixed capture pattern in the instruction register's two low bits
`define TID_IR_CAPTURE 2'h1
// Register lengths and the default boundary chain length
`define TID_ID_W 32
`define TID_BSR_W 16
// Consecutive high TMS samples that force Test-Logic-Reset
`define TID_RESET_TMS_COUNT 5
// Identification code store, arbitrary value, lsb set per convention
`define TID_ID_VALUE 32'h0a5c_0001

`endif

// ===== include/tid_pkg.sv
/*
 * Holds the types of the boundary-scan test port: controller states and
 * the selected data path. Assumes nothing beyond a SystemVerilog compiler.
 */
package tid_pkg;

    // TAP controller states
    typedef enum logic [3:0] {
        TID_RESET, TID_IDLE, TID_SEL_DR, TID_CAP_DR, TID_SHF_DR, TID_EX1_DR,
        TID_PAU_DR, TID_EX2_DR, TID_UPD_DR, TID_SEL_IR, TID_CAP_IR, TID_SHF_IR,
        TID_EX1_IR, TID_PAU_IR, TID_EX2_IR, TID_UPD_IR
    } tid_state_t;

    // Data register placed between the serial input and output
    typedef enum logic [1:0] {
        TID_PATH_BSR, TID_PATH_ID, TID_PATH_BYP
    } tid_path_t;

endpackage

// ===== src/tid_decode.sv
/*
 * Decodes the active 3-bit instruction into the data path selection and
 * the output high-impedance request. Assumes a stable, held instruction.
 */
`include "tid_defines.svh"

module tid_decode
    import tid_pkg::*;
(
    // Instruction in force
    input wire logic [`TID_IR_W-1:0] instr,
    // Decoded controls
    output tid_path_t path,
    output logic force_hiz
);

    // Code to path, reserved codes act as bypass
    always_comb begin
        force_hiz = 1'b0;
        case (instr)
            `TID_OP_EXTEST: path = TID_PATH_BSR;
            `TID_OP_IDCODE: path = TID_PATH_ID;
            `TID_OP_SAMPLE_Z: begin
                path = TID_PATH_BSR;
                force_hiz = 1'b1;
            end
            `TID_OP_SAMPLE: path = TID_PATH_BSR;
            `TID_OP_BYPASS: path = TID_PATH_BYP;
            default: path = TID_PATH_BYP;
        endcase
    end

endmodule

// ===== testbench/tid_tap_assertions.sv
/* Checker of the test port outputs, seeing only the pins of tid_tap.
   Assumes the partner holds tck high and low for at least four clocks. */
module tid_tap_assertions
#(
    parameter int BSR_W = 16
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Test pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    // Memory side
    input wire logic [BSR_W-1:0] ring_in,
    input wire logic mem_out_hiz,
    input wire logic [BSR_W-1:0] ring_out,
    input wire logic extest_drive
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic tck_q;
    logic [2:0] high_run;
    // Run of test clock rises seen with tms high, saturating at five
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tck_q <= 1'b0;
            high_run <= 3'h0;
        end else begin
            tck_q <= tck;
            if (tck && !tck_q) begin
                high_run <= !tms ? 3'h0 : (high_run == 3'h5) ? 3'h5 : high_run + 3'h1;
            end
        end
    end
    hiz_ext_excl_a: assert property (!(mem_out_hiz && extest_drive))
        else $error("high impedance and drive both set");
    reset_quiet_a: assert property ($rose(rst_n) |-> (!mem_out_hiz && !extest_drive)[*4])
        else $error("outputs active after reset");
    tms_reset_a: assert property (high_run == 3'h5 |-> ##[1:8] (!mem_out_hiz && !extest_drive))
        else $error("tms high run did not restore identification");
    pin_timing_a: assert property (($changed(tdo) || $changed(tdo_oe)) |-> !tck)
        else $error("serial output moved while test clock high");
    instr_hold_a: assert property (tdo_oe |-> $stable(mem_out_hiz) && $stable(extest_drive))
        else $error("instruction changed during shift");
    ring_hold_a: assert property ($changed(ring_out) |-> !tdo_oe)
        else $error("ring output changed during shift");
    hiz_rise_a: assert property ($rose(mem_out_hiz) |-> !$past(tck) && !tdo_oe)
        else $error("high impedance rose outside update");
    ext_rise_a: assert property ($rose(extest_drive) |-> !$past(tck) && !tdo_oe)
        else $error("drive rose outside update");
endmodule

bind tid_tap tid_tap_assertions #(.BSR_W(BSR_W)) chk (.clock(clock), .rst_n(rst_n), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in),
    .mem_out_hiz(mem_out_hiz), .ring_out(ring_out), .extest_drive(extest_drive));

// ===== testbench/tid_jtag_model.sv
/* External boundary-scan controller: drives tck, tms and tdi on request.
   Assumes the caller starts scans from Run-Test/Idle. */
module tid_jtag_model (
    // System clock
    input wire logic clock,
    // Test pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One test clock period of eight clocks, four low and four high;
    // tck stands low between calls
    task step(input logic m, input logic d, output logic q);
        @(posedge clock);
        tms <= m;
        tdi <= d;
        repeat (3) @(posedge clock);
        q = tdo;
        tck <= 1'b1;
        repeat (4) @(posedge clock);
        tck <= 1'b0;
        tdi <= 1'b1; // Released line reads high, like an open input
    endtask
    // Five high tms rises, then to Idle
    task tlr();
        logic q;
        repeat (5) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
    // Whole scan from Idle back to Idle, codes sent LSB first as commanded
    task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b1, q);
        if (ir) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
endmodule

// ===== testbench/tb.sv
/* Self-checking bench of tid_tap: public codes through a table, reserved codes, then resets.
   Assumes the controller model in tid_jtag_model. */
`include "tid_defines.svh"
module tb;
    import tid_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] ring_in = 16'hc35a;
    logic tck, tms, tdi, tdo, tdo_oe, mem_out_hiz, extest_drive;
    logic [15:0] ring_out;
    logic [31:0] got;
    logic [31:0] din = 32'h9e37_21b4;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    logic q;
    // Ordinary rows: public codes only, beside the decode each should give
    typedef struct packed {
        logic [2:0] code;
        tid_path_t path;
        logic hiz;
        logic drive;
    } tid_row_t;
    tid_row_t rows [5] = '{
        '{`TID_OP_EXTEST, TID_PATH_BSR, 1'b0, 1'b1},
        '{`TID_OP_IDCODE, TID_PATH_ID, 1'b0, 1'b0},
        '{`TID_OP_SAMPLE_Z, TID_PATH_BSR, 1'b1, 1'b0},
        '{`TID_OP_SAMPLE, TID_PATH_BSR, 1'b0, 1'b0},
        '{`TID_OP_BYPASS, TID_PATH_BYP, 1'b0, 1'b0}};
    always #12.5 clock = ~clock;
    tid_tap dut (.clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .ring_in(ring_in), .mem_out_hiz(mem_out_hiz), .ring_out(ring_out),
        .extest_drive(extest_drive));
    tid_jtag_model jtag (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Bits out of a 32-bit data scan for a path
    function automatic logic [31:0] dr_exp(tid_path_t p);
        if (p == TID_PATH_BSR) return {din[15:0], ring_in};
        if (p == TID_PATH_ID) return `TID_ID_VALUE;
        return {din[30:0], 1'b0};
    endfunction
    // Load one code, then check its decode and one full data scan
    task run_code(input logic [2:0] code, input tid_path_t p, input logic hiz,
        input logic drv);
        jtag.scan(1'b1, 3, {29'h0, code}, got);
        check("ir capture", got, 32'h1);
        check("hiz", mem_out_hiz, hiz);
        check("drive", extest_drive, drv);
        check("oe after ir", tdo_oe, 1'b0);
        jtag.scan(1'b0, 32, din, got);
        check("dr path", got, dr_exp(p));
        check("hiz held", mem_out_hiz, hiz);
    endtask
    task end_of_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        check("reset ring", ring_out, 32'h0);
        jtag.tlr();
        jtag.scan(1'b0, 32, din, got);
        check("reset path", got, dr_exp(TID_PATH_ID));
        // Table of public codes
        foreach (rows[r]) begin
            run_code(rows[r].code, rows[r].path, rows[r].hiz, rows[r].drive);
        end
        // Reserved codes, loaded on purpose against the controller's rule
        run_code(`TID_OP_RSV_A, TID_PATH_BYP, 1'b0, 1'b0);
        run_code(`TID_OP_RSV_B, TID_PATH_BYP, 1'b0, 1'b0);
        run_code(`TID_OP_RSV_C, TID_PATH_BYP, 1'b0, 1'b0);
        // Preload a ring pattern, then keep it while the drive code is loaded
        jtag.scan(1'b1, 3, {29'h0, `TID_OP_SAMPLE}, got);
        jtag.scan(1'b0, 16, 32'h0000_5a3c, got);
        check("preload capture", got, {16'h0, ring_in});
        check("ring out", ring_out, 32'h5a3c);
        jtag.scan(1'b1, 3, {29'h0, `TID_OP_EXTEST}, got);
        check("ring held", ring_out, 32'h5a3c);
        check("drive set", extest_drive, 1'b1);
        // Output enable stands only while shifting
        jtag.step(1'b1, 1'b1, q);
        jtag.step(1'b0, 1'b1, q);
        jtag.step(1'b0, 1'b1, q);
        jtag.step(1'b0, 1'b1, q);
        check("oe shift", tdo_oe, 1'b1);
        jtag.step(1'b1, 1'b1, q);
        jtag.step(1'b1, 1'b1, q);
        jtag.step(1'b0, 1'b1, q);
        check("oe idle", tdo_oe, 1'b0);
        // Tms reset while high impedance in force
        jtag.scan(1'b1, 3, 32'h2, got);
        check("hiz set", mem_out_hiz, 1'b1);
        jtag.tlr();
        check("hiz clear", mem_out_hiz, 1'b0);
        jtag.scan(1'b0, 32, din, got);
        check("tlr path", got, dr_exp(TID_PATH_ID));
        // Reset in mid-run while high impedance in force
        jtag.scan(1'b1, 3, 32'h2, got);
        check("hiz again", mem_out_hiz, 1'b1);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (6) @(posedge clock);
        check("reset hiz", mem_out_hiz, 1'b0);
        check("reset ring again", ring_out, 32'h0);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        jtag.step(1'b0, 1'b1, q);
        jtag.scan(1'b0, 32, din, got);
        check("power-up path", got, dr_exp(TID_PATH_ID));
        end_of_test();
    end
endmodule
